/* File: rtl/card_run_command_control.v */
// Overview of operation
// - command register is write-only; several command bits may go in one write
// - any command bit not allowed in the present state rejects the whole write
// - bit 1h performs a full reset of card state
// - bit 2h loads configuration into hardware without starting
// - bit 4h starts a run, loading configuration in the same cycle if it changed
// - while running only live-capable settings accept changes
// - bit 8h enables trigger detection, with start or later
// - bit 10h forces a trigger; with start it acts as software trigger
// - bit 20h disables detection; triggers ignored until enabled again
// - a start leaves detection disabled unless enable comes with it
// - bit 40h stops the run; no effect when idle
// - waits end with success, timeout or abort by stop or reset
// - wait 1000h ends when pretrigger area first fills; acquisition only
// - wait 2000h ends on first trigger only
// - wait 4000h ends when the run has completed
// - timeout register holds milliseconds; zero disables it
// - with no timeout a wait that never reaches its target blocks forever
// - timeout disabled after reset; nonzero value applies to later waits until rewritten or cleared by full reset (bit 1h)
// - a timeout leaves run state untouched
`timescale 1ns/1ps
`include "card_run_consts.vh"

module card_run_command_control #(
   parameter MS_CYCLES = `MS_CYCLES
) (
   input wire mclk,
   input wire reset,
   input wire regWrite,
   input wire regRead,
   input wire [31:0] regAddr,
   input wire [31:0] regWrData,
   output reg [31:0] regRdData,
   output reg regRdValid,
   input wire acqMode,
   input wire trigPin,
   input wire pretrigFull,
   input wire runEnded,
   input wire settingsChanged,
   input wire settingWrite,
   input wire settingLive,
   output reg settingAccept,
   output reg runActive,
   output reg trigDetectEn,
   output reg trigAccept,
   output reg loadConfig,
   output reg runStart,
   output reg runHalt,
   output reg fullReset,
   output reg execDone,
   output reg [1:0] execResult,
   output reg waitBusy,
   output reg waitDone,
   output reg [1:0] waitResult
);
   reg [31:0] waitTimeoutReg;
   reg configDirty;
   reg pretrigSeen;
   reg trigSeen;
   reg readySeen;
   reg [1:0] waitSel;
   reg trigSync1;
   reg trigSync2;
   reg trigPrev;
   wire cmdWrite;
   wire tmoWrite;
   wire reject;
   wire timerExpired;
   wire cmdOk;
   wire doReset;
   wire doLoad;
   wire doStart;
   wire doTrigOn;
   wire doTrigOff;
   wire doForce;
   wire doHalt;
   wire [1:0] newWaitSel;
   wire trigRise;
   wire trigHit;
   wire abortWait;
   wire waitHit;
   wire timerArm;
   wire timerStop;
   wire tmoRead;
   reg next_waitDone;
   reg [1:0] next_waitResult;

   function [1:0] waitSelect;
      input [31:0] cmd;
      begin
         if (cmd[`WAIT_PRETRIG_BIT])
            waitSelect = `WSEL_PRETRIG;
         else if (cmd[`WAIT_TRIG_BIT])
            waitSelect = `WSEL_TRIG;
         else if (cmd[`WAIT_DONE_BIT])
            waitSelect = `WSEL_DONE;
         else
            waitSelect = `WSEL_NONE;
      end
   endfunction

   function addrHit;
      input [31:0] addr;
      input [31:0] target;
      begin
         addrHit = (addr == target);
      end
   endfunction

   assign cmdWrite = regWrite && addrHit(regAddr, `CMD_REG_ADDR);
   assign tmoWrite = regWrite && addrHit(regAddr, `TMO_REG_ADDR);
   assign tmoRead = regRead && addrHit(regAddr, `TMO_REG_ADDR);
   assign cmdOk = cmdWrite && !reject;

   // each bit decoded independently, so one write carries several
   assign doReset = cmdOk && regWrData[`CMD_FULL_RESET_BIT];
   assign doLoad = cmdOk && regWrData[`CMD_LOAD_CONFIG_BIT];
   assign doStart = cmdOk && regWrData[`CMD_RUN_BEGIN_BIT];
   assign doTrigOn = cmdOk && regWrData[`CMD_TRIG_ON_BIT];
   assign doTrigOff = cmdOk && regWrData[`CMD_TRIG_OFF_BIT];
   assign doForce = cmdOk && regWrData[`CMD_TRIG_FORCE_BIT];
   assign doHalt = cmdOk && regWrData[`CMD_RUN_HALT_BIT] && runActive;
   assign newWaitSel = cmdOk ? waitSelect(regWrData) : `WSEL_NONE;

   cmd_seq_check u_check (
      .cmd(regWrData),
      .runActive(runActive),
      .acqMode(acqMode),
      .waitBusy(waitBusy),
      .pretrigSeen(pretrigSeen),
      .trigSeen(trigSeen),
      .readySeen(readySeen),
      .reject(reject)
   );

   assign timerArm = (newWaitSel != `WSEL_NONE);
   // timer stops once the wait has ended for any reason
   assign timerStop = waitDone || doReset || (waitBusy && (waitHit || abortWait));

   wait_ms_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .reset(reset),
      .arm(timerArm),
      .disarm(timerStop),
      .limitMs(waitTimeoutReg),
      .expired(timerExpired)
   );

   // trigger pin crosses in through two flops
   always @(posedge mclk) begin
      if (reset) begin
         trigSync1 <= 1'b0;
         trigSync2 <= 1'b0;
         trigPrev <= 1'b0;
      end else begin
         trigSync1 <= trigPin;
         trigSync2 <= trigSync1;
         trigPrev <= trigSync2;
      end
   end

   assign trigRise = trigSync2 && !trigPrev;
   // detection looks only after prefill in acquisition disabled means ignored
   assign trigHit = runActive && trigDetectEn && trigRise && (pretrigSeen || !acqMode);

   assign waitHit = ((waitSel == `WSEL_PRETRIG) && pretrigSeen)
      || ((waitSel == `WSEL_TRIG) && trigSeen)
      || ((waitSel == `WSEL_DONE) && readySeen);
   assign abortWait = doReset || doHalt;

   // wait completion: success beats abort beats timeout
   always @* begin
      next_waitDone = 1'b0;
      next_waitResult = waitResult;
      if (waitBusy) begin
         if (waitHit) begin
            next_waitDone = 1'b1;
            next_waitResult = `RES_OK;
         end else if (abortWait) begin
            next_waitDone = 1'b1;
            next_waitResult = `RES_ABORT;
         end else if (timerExpired) begin
            next_waitDone = 1'b1;
            next_waitResult = `RES_TIMEOUT;
         end
      end
   end

   // register port and result strobes
   always @(posedge mclk) begin
      if (reset) begin
         waitTimeoutReg <= `TMO_RESET_VAL;
         regRdData <= 32'h00000000;
         regRdValid <= 1'b0;
         execDone <= 1'b0;
         execResult <= `RES_OK;
         settingAccept <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (tmoRead)
            regRdData <= waitTimeoutReg;
         else if (regRead)
            regRdData <= 32'h00000000;
         if (doReset)
            waitTimeoutReg <= `TMO_RESET_VAL;
         else if (tmoWrite)
            waitTimeoutReg <= regWrData;
         execDone <= cmdWrite;
         if (cmdWrite)
            execResult <= reject ? `RES_SEQUENCE : `RES_OK;
         // live-capable settings only while running
         settingAccept <= settingWrite && (!runActive || settingLive);
      end
   end

   // run state, trigger state and wait tracking
   always @(posedge mclk) begin
      if (reset) begin
         runActive <= 1'b0;
         trigDetectEn <= 1'b0;
         trigAccept <= 1'b0;
         loadConfig <= 1'b0;
         runStart <= 1'b0;
         runHalt <= 1'b0;
         fullReset <= 1'b0;
         configDirty <= 1'b1;
         pretrigSeen <= 1'b0;
         trigSeen <= 1'b0;
         readySeen <= 1'b0;
         waitSel <= `WSEL_NONE;
         waitBusy <= 1'b0;
         waitDone <= 1'b0;
         waitResult <= `RES_OK;
      end else begin
         waitDone <= next_waitDone;
         waitResult <= next_waitResult;
         if (next_waitDone) begin
            waitBusy <= 1'b0;
            waitSel <= `WSEL_NONE;
         end
         if (doReset) begin
            // state back to power-up; pending wait aborts above
            runActive <= 1'b0;
            trigDetectEn <= 1'b0;
            trigAccept <= 1'b0;
            loadConfig <= 1'b0;
            runStart <= 1'b0;
            runHalt <= 1'b0;
            fullReset <= 1'b1;
            configDirty <= 1'b1;
            pretrigSeen <= 1'b0;
            trigSeen <= 1'b0;
            readySeen <= 1'b0;
         end else begin
            fullReset <= 1'b0;
            // load happens on explicit request or on start with changed settings
            loadConfig <= doLoad || (doStart && configDirty);
            if (doLoad || doStart)
               configDirty <= 1'b0;
            else if (settingsChanged && !runActive)
               configDirty <= 1'b1;
            // a change arriving with the load stays pending
            if ((doLoad || doStart) && settingsChanged)
               configDirty <= 1'b1;
            runStart <= doStart;
            runHalt <= doHalt;
            if (doStart) begin
               runActive <= 1'b1;
               pretrigSeen <= 1'b0;
               trigSeen <= doForce;
               readySeen <= 1'b0;
            end else if (doHalt) begin
               runActive <= 1'b0;
            end else if (runActive) begin
               if (runEnded) begin
                  runActive <= 1'b0;
                  readySeen <= 1'b1;
               end
               if (pretrigFull && acqMode)
                  pretrigSeen <= 1'b1;
               if (trigHit || doForce)
                  trigSeen <= 1'b1;
            end
            // start clears detection unless enable rides along
            if (doTrigOn)
               trigDetectEn <= 1'b1;
            else if (doTrigOff || doStart || doHalt)
               trigDetectEn <= 1'b0;
            else if (runActive && runEnded)
               trigDetectEn <= 1'b0;
            trigAccept <= trigHit || doForce;
         end
         if (newWaitSel != `WSEL_NONE) begin
            waitBusy <= 1'b1;
            waitSel <= newWaitSel;
         end
      end
   end
endmodule // card_run_command_control

/* File: rtl/card_run_consts.vh */
`ifndef CARD_RUN_CONSTS_VH
`define CARD_RUN_CONSTS_VH

// register numbers as seen by host software
`define CMD_REG_ADDR 32'h00000064
`define TMO_REG_ADDR 32'h000480DA
`define TMO_RESET_VAL 32'h00000000

// command bit positions
`define CMD_FULL_RESET_BIT 0
`define CMD_LOAD_CONFIG_BIT 1
`define CMD_RUN_BEGIN_BIT 2
`define CMD_TRIG_ON_BIT 3
`define CMD_TRIG_FORCE_BIT 4
`define CMD_TRIG_OFF_BIT 5
`define CMD_RUN_HALT_BIT 6
`define WAIT_PRETRIG_BIT 12
`define WAIT_TRIG_BIT 13
`define WAIT_DONE_BIT 14

// completion codes
`define RES_OK 2'h0
`define RES_SEQUENCE 2'h1
`define RES_TIMEOUT 2'h2
`define RES_ABORT 2'h3

// wait selector codes
`define WSEL_NONE 2'h0
`define WSEL_PRETRIG 2'h1
`define WSEL_TRIG 2'h2
`define WSEL_DONE 2'h3

// timing
`define CLK_PERIOD_NS 10
`define MS_PERIOD_NS 1000000
`define MS_CYCLES ((`MS_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/wait_ms_timer.v */
`timescale 1ns/1ps
`include "card_run_consts.vh"

module wait_ms_timer #(
   parameter MS_CYCLES = `MS_CYCLES
) (
   input wire mclk,
   input wire reset,
   input wire arm,
   input wire disarm,
   input wire [31:0] limitMs,
   output reg expired
);
   reg running;
   reg [31:0] limit;
   reg [31:0] divCount;
   reg [31:0] msCount;
   wire msTick;

   assign msTick = running && (divCount == MS_CYCLES - 1);

   always @(posedge mclk) begin
      if (reset) begin
         running <= 1'b0;
         limit <= `TMO_RESET_VAL;
         divCount <= 32'h00000000;
         msCount <= 32'h00000000;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (arm) begin
            // zero limit leaves the timer idle: wait blocks forever
            running <= (limitMs != `TMO_RESET_VAL);
            limit <= limitMs;
            divCount <= 32'h00000000;
            msCount <= 32'h00000000;
         end else if (disarm) begin
            running <= 1'b0;
         end else if (running) begin
            if (msTick) begin
               divCount <= 32'h00000000;
               if (msCount + 32'h00000001 == limit) begin
                  running <= 1'b0;
                  expired <= 1'b1;
               end
               msCount <= msCount + 32'h00000001;
            end else begin
               divCount <= divCount + 32'h00000001;
            end
         end
      end
   end
endmodule // wait_ms_timer

/* File: rtl/cmd_seq_check.v */
`timescale 1ns/1ps
`include "card_run_consts.vh"

module cmd_seq_check (
   input wire [31:0] cmd,
   input wire runActive,
   input wire acqMode,
   input wire waitBusy,
   input wire pretrigSeen,
   input wire trigSeen,
   input wire readySeen,
   output reg reject
);
   reg isReset;
   reg isStart;
   reg isHalt;
   reg trigCmd;
   reg [2:0] waits;
   reg anyWait;
   reg multiWait;
   reg targetSeen;
   reg running;

   always @* begin
      isReset = cmd[`CMD_FULL_RESET_BIT];
      isStart = cmd[`CMD_RUN_BEGIN_BIT];
      isHalt = cmd[`CMD_RUN_HALT_BIT];
      trigCmd = cmd[`CMD_TRIG_ON_BIT] | cmd[`CMD_TRIG_OFF_BIT] | cmd[`CMD_TRIG_FORCE_BIT];
      waits = {cmd[`WAIT_DONE_BIT], cmd[`WAIT_TRIG_BIT], cmd[`WAIT_PRETRIG_BIT]};
      anyWait = |waits;
      multiWait = (waits[0] & waits[1]) | (waits[0] & waits[2]) | (waits[1] & waits[2]);
      targetSeen = (waits[0] & pretrigSeen) | (waits[1] & trigSeen) | (waits[2] & readySeen);
      running = runActive | isStart;
      reject = 1'b0;
      // reset must stand alone
      if (isReset && (cmd[`CMD_RUN_HALT_BIT:`CMD_LOAD_CONFIG_BIT] != 6'h00 || anyWait))
         reject = 1'b1;
      if (isStart && (runActive || isHalt))
         reject = 1'b1;
      if (cmd[`CMD_TRIG_ON_BIT] && cmd[`CMD_TRIG_OFF_BIT])
         reject = 1'b1;
      if (trigCmd && !running)
         reject = 1'b1;
      if (anyWait && (multiWait || waitBusy || isHalt || isReset))
         reject = 1'b1;
      // prefill wait exists in acquisition only
      if (waits[0] && !acqMode)
         reject = 1'b1;
      if (anyWait && !running && !targetSeen)
         reject = 1'b1;
   end
endmodule // cmd_seq_check

/* File: bench/card_run_command_control_asserts.sv */
`timescale 1ns/1ps
`include "card_run_consts.vh"

module card_run_command_control_asserts #(
   parameter MS_CYCLES = 100000
) (
   input logic mclk,
   input logic reset,
   input logic regWrite,
   input logic regRead,
   input logic [31:0] regAddr,
   input logic [31:0] regWrData,
   input logic [31:0] regRdData,
   input logic regRdValid,
   input logic acqMode,
   input logic trigPin,
   input logic pretrigFull,
   input logic runEnded,
   input logic settingsChanged,
   input logic settingWrite,
   input logic settingLive,
   input logic settingAccept,
   input logic runActive,
   input logic trigDetectEn,
   input logic trigAccept,
   input logic loadConfig,
   input logic runStart,
   input logic runHalt,
   input logic fullReset,
   input logic execDone,
   input logic [1:0] execResult,
   input logic waitBusy,
   input logic waitDone,
   input logic [1:0] waitResult
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic cw;
   assign cw = regWrite && regAddr == `CMD_REG_ADDR;
   property p_exec; cw |=> execDone; endproperty
   a_exec: assert property (p_exec) else $error("no execDone after command write");
   property p_seq; cw && regWrData == 32'h00000005 |=> execResult == `RES_SEQUENCE && !runStart && !fullReset; endproperty
   a_seq: assert property (p_seq) else $error("reset with start not refused");
   property p_start; cw && regWrData == 32'h00000004 && !runActive |=> runStart && runActive && !trigDetectEn; endproperty
   a_start: assert property (p_start) else $error("start wrong or detection left on");
   property p_load; cw && regWrData == 32'h00000002 && !runActive |=> loadConfig && !runStart && !runActive; endproperty
   a_load: assert property (p_load) else $error("load config wrong");
   property p_rst; cw && regWrData == 32'h00000001 |=> fullReset && !runActive; endproperty
   a_rst: assert property (p_rst) else $error("full reset wrong");
   property p_off; cw && regWrData == 32'h00000020 && runActive |=> !trigDetectEn; endproperty
   a_off: assert property (p_off) else $error("detection not disabled");
   property p_halt_idle; cw && regWrData == 32'h00000040 && !runActive |=> !runHalt && execResult == `RES_OK; endproperty
   a_halt_idle: assert property (p_halt_idle) else $error("stop while idle had effect");
   property p_setting; settingWrite |=> settingAccept == (!$past(runActive) || $past(settingLive)); endproperty
   a_setting: assert property (p_setting) else $error("setting accept wrong");
   property p_wdone; waitDone |-> !waitBusy && $past(waitBusy); endproperty
   a_wdone: assert property (p_wdone) else $error("waitDone without pending wait");
   property p_tmo; waitDone && waitResult == `RES_TIMEOUT |-> runActive == $past(runActive); endproperty
   a_tmo: assert property (p_tmo) else $error("timeout changed run state");
   property p_rd; regRead && regAddr == `CMD_REG_ADDR |=> regRdValid && regRdData == 32'h00000000; endproperty
   a_rd: assert property (p_rd) else $error("command register readable");
endmodule // card_run_command_control_asserts

bind card_run_command_control card_run_command_control_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

/* File: bench/tb_card_run_command_control.sv */
`timescale 1ns/1ps
`include "card_run_consts.vh"

module tb_card_run_command_control;
   logic mclk = 0, reset = 1, regWrite = 0, regRead = 0, acqMode = 1, trigPin = 0;
   logic pretrigFull = 0, runEnded = 0, settingsChanged = 0, settingWrite = 0, settingLive = 0;
   logic [31:0] regAddr = 32'h0, regWrData = 32'h0, regRdData;
   logic regRdValid, settingAccept, runActive, trigDetectEn, trigAccept, loadConfig, runStart;
   logic runHalt, fullReset, execDone, waitBusy, waitDone, seenTrig;
   logic [1:0] execResult, waitResult;
   int n_mismatch = 0, total_checks = 0, i;
   always #5 mclk = ~mclk;
   card_run_command_control #(.MS_CYCLES(10)) dut (.mclk(mclk), .reset(reset), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .acqMode(acqMode), .trigPin(trigPin), .pretrigFull(pretrigFull),
      .runEnded(runEnded), .settingsChanged(settingsChanged), .settingWrite(settingWrite),
      .settingLive(settingLive), .settingAccept(settingAccept), .runActive(runActive),
      .trigDetectEn(trigDetectEn), .trigAccept(trigAccept), .loadConfig(loadConfig), .runStart(runStart),
      .runHalt(runHalt), .fullReset(fullReset), .execDone(execDone), .execResult(execResult),
      .waitBusy(waitBusy), .waitDone(waitDone), .waitResult(waitResult));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge mclk);
      regWrite = 1;
      regAddr = a;
      regWrData = d;
      @(negedge mclk);
      regWrite = 0;
   endtask
   task cmd(input logic [31:0] d, input logic [1:0] res);
      wr(`CMD_REG_ADDR, d);
      chk("execDone", {31'h0, execDone}, 32'h1);
      chk("execResult", {30'h0, execResult}, {30'h0, res});
   endtask
   task rd(input logic [31:0] a, input logic [31:0] exp);
      @(negedge mclk);
      regRead = 1;
      regAddr = a;
      @(negedge mclk);
      regRead = 0;
      chk("regRdValid", {31'h0, regRdValid}, 32'h1);
      chk("regRdData", regRdData, exp);
   endtask
   task bit1(input string nm, input logic seen, input logic exp);
      chk(nm, {31'h0, seen}, {31'h0, exp});
   endtask
   task setw(input logic live, input logic exp);
      @(negedge mclk);
      settingLive = live;
      settingWrite = 1;
      @(negedge mclk);
      settingWrite = 0;
      settingLive = 0;
      bit1("settingAccept", settingAccept, exp);
   endtask
   // waitDone is a one-cycle pulse, so look before stepping
   task waitEnd(input int lim, input logic [1:0] exp);
      for (i = 0; i < lim; i++) begin
         if (waitDone === 1'b1) break;
         @(negedge mclk);
      end
      if (waitDone !== 1'b1) begin
         n_mismatch++;
         $display("mismatch waitDone expected 1 seen 0");
         wrap_up;
      end else chk("waitResult", {30'h0, waitResult}, {30'h0, exp});
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      reset = 0;
      rd(`TMO_REG_ADDR, 32'h0);
      rd(`CMD_REG_ADDR, 32'h0);
      rd(32'h00000010, 32'h0);
      cmd(32'h00000005, `RES_SEQUENCE);
      bit1("runActive", runActive, 1'b0);
      cmd(32'h00000008, `RES_SEQUENCE);
      cmd(32'h00000002, `RES_OK);
      bit1("loadConfig", loadConfig, 1'b1);
      bit1("runActive", runActive, 1'b0);
      @(negedge mclk);
      settingsChanged = 1;
      @(negedge mclk);
      settingsChanged = 0;
      cmd(32'h00000004, `RES_OK);
      bit1("runStart", runStart, 1'b1);
      bit1("loadConfig", loadConfig, 1'b1);
      bit1("trigDetectEn", trigDetectEn, 1'b0);
      cmd(32'h00000004, `RES_SEQUENCE);
      setw(1'b0, 1'b0);
      setw(1'b1, 1'b1);
      cmd(32'h00001000, `RES_OK);
      pretrigFull = 1;
      @(negedge mclk);
      pretrigFull = 0;
      waitEnd(20, `RES_OK);
      cmd(32'h00000008, `RES_OK);
      bit1("trigDetectEn", trigDetectEn, 1'b1);
      cmd(32'h00000020, `RES_OK);
      bit1("trigDetectEn", trigDetectEn, 1'b0);
      seenTrig = 0;
      trigPin = 1;
      repeat (10) begin
         @(negedge mclk);
         if (trigAccept === 1'b1) seenTrig = 1;
      end
      trigPin = 0;
      bit1("trigAccept", seenTrig, 1'b0);
      cmd(32'h00000008, `RES_OK);
      bit1("trigDetectEn", trigDetectEn, 1'b1);
      cmd(32'h00002000, `RES_OK);
      trigPin = 1;
      waitEnd(20, `RES_OK);
      trigPin = 0;
      wr(`TMO_REG_ADDR, 32'h00000002);
      rd(`TMO_REG_ADDR, 32'h00000002);
      cmd(32'h00004000, `RES_OK);
      repeat (15) @(negedge mclk);
      bit1("waitBusy", waitBusy, 1'b1);
      waitEnd(40, `RES_TIMEOUT);
      bit1("runActive", runActive, 1'b1);
      cmd(32'h00004000, `RES_OK);
      waitEnd(40, `RES_TIMEOUT);
      cmd(32'h00004000, `RES_OK);
      runEnded = 1;
      @(negedge mclk);
      runEnded = 0;
      waitEnd(20, `RES_OK);
      wr(`TMO_REG_ADDR, 32'h00000005);
      cmd(32'h00000001, `RES_OK);
      bit1("fullReset", fullReset, 1'b1);
      bit1("runActive", runActive, 1'b0);
      rd(`TMO_REG_ADDR, 32'h0);
      cmd(32'h00000040, `RES_OK);
      bit1("runHalt", runHalt, 1'b0);
      cmd(32'h00000014, `RES_OK);
      bit1("trigAccept", trigAccept, 1'b1);
      bit1("trigDetectEn", trigDetectEn, 1'b0);
      cmd(32'h00002000, `RES_OK);
      waitEnd(5, `RES_OK);
      cmd(32'h00004000, `RES_OK);
      repeat (50) @(negedge mclk);
      bit1("waitBusy", waitBusy, 1'b1);
      cmd(32'h00000040, `RES_OK);
      bit1("runHalt", runHalt, 1'b1);
      waitEnd(10, `RES_ABORT);
      cmd(32'h0000000C, `RES_OK);
      bit1("trigDetectEn", trigDetectEn, 1'b1);
      cmd(32'h00000028, `RES_SEQUENCE);
      acqMode = 0;
      cmd(32'h00001000, `RES_SEQUENCE);
      cmd(32'h00002000, `RES_OK);
      trigPin = 1;
      waitEnd(20, `RES_OK);
      trigPin = 0;
      wrap_up;
   end
endmodule // tb_card_run_command_control
